// [hdl/fpbs_crc32_step.v]
// one byte step of the reflected 32-bit crc
`timescale 1ns/10ps
`include "fpbs_defs.vh"
module fpbs_crc32_step (
  input wire [31:0] crc_in,
  input wire [7:0] data_in,
  output reg [31:0] crc_out
);
  integer i;
  reg [31:0] c;
  always @* begin
    c = crc_in ^ {24'h000000, data_in};
    for (i = 0; i < 8; i = i + 1) begin
      c = c[0] ? ((c >> 1) ^ `FPBS_CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule

// [hdl/fpbs_defs.vh]
// constants for the flash program/erase and boot select block
// Summary of operation
// R01: one command erases a single 1 kB sector or a single 64-byte page.
// R02: single bytes can be erased, read and programmed for data storage.
// R03: one command erases the whole program array.
// R04: a 64-byte page buffer programs one to 64 bytes of a page at once.
// R05: erase and program timing is made inside; each operation ends within 2 ms.
// R06: the array is eight or sixteen 1 kB sectors of 64-byte pages.
// R07: code-space reads of secured sectors are refused; unsecured reads are served.
// R08: a 32-bit CRC covers one chosen sector or the whole user code space.
// R09: boot status zero starts fetch at 0000H after reset.
// R10: boot status non-zero starts at boot vector as high byte, low byte 00H.
// R11: default boot vector is 1FH on small and 3FH on large arrays.
// R12: a forced loader entry at power-on acts as non-zero boot status.
// R13: a call to FF03H runs the service chosen by preloaded core registers.
// R14: four registers give access: control/status, data and two address bytes.
// R15: the configuration byte is taken at power-up and is fixed afterwards; the code takes it again at every reset release.
// R16: one security byte per sector guards that sector.
// R17: the shipped serial loader sits in the top 512 bytes of code space.
// R18: an external programmer sends commands over a two-wire clock and data link.
// R19: the loader should clear boot status after programming to run from 0000H.
// R20: loader users should page-erase the first eight pages, not the sector.
// R21: busy shows during erase, program or CRC; new requests are ignored meanwhile; serial-link read frames are still answered from the array.
// R22: erased bytes read back as all ones.
`ifndef FPBS_DEFS_VH
`define FPBS_DEFS_VH
`define FPBS_OFF_CTRL 8'h00
`define FPBS_OFF_DATA 8'h04
`define FPBS_OFF_ADDRL 8'h08
`define FPBS_OFF_ADDRH 8'h0C
`define FPBS_OFF_CRC 8'h10
`define FPBS_OFF_BOOT 8'h14
`define FPBS_OFF_CFG 8'h18
`define FPBS_CTRL_CLR_BIT 7
`define FPBS_CMD_NONE 4'h0
`define FPBS_CMD_BYTE_ERASE 4'h1
`define FPBS_CMD_PAGE_ERASE 4'h2
`define FPBS_CMD_SECT_ERASE 4'h3
`define FPBS_CMD_CHIP_ERASE 4'h4
`define FPBS_CMD_LOAD 4'h5
`define FPBS_CMD_PROGRAM 4'h6
`define FPBS_CMD_CRC_SECT 4'h7
`define FPBS_CMD_CRC_ALL 4'h8
`define FPBS_CMD_WR_SEC 4'h9
`define FPBS_CMD_WR_BSTAT 4'hA
`define FPBS_CMD_WR_BVEC 4'hB
`define FPBS_CMD_READ 4'hC
`define FPBS_CMD_WR_CFG 4'hD
`define FPBS_PAGE_BYTES 16'h0040
`define FPBS_SECTOR_BYTES 16'h0400
`define FPBS_LOADER_BYTES 16'h0200
`define FPBS_ERASED 8'hFF
`define FPBS_ROM_ENTRY 16'hFF03
`define FPBS_VEC_SMALL 8'h1F
`define FPBS_VEC_LARGE 8'h3F
`define FPBS_BOOT_LOW 8'h00
`define FPBS_CRC_INIT 32'hFFFFFFFF
`define FPBS_CRC_POLY 32'hEDB88320
`define FPBS_OP_TIME_US 2000
`define FPBS_CLK_MHZ 100
`define FPBS_ICP_FRAME_BITS 6'd32
`define FPBS_ICP_OUT_BITS 4'h8
`endif

// [hdl/fpbs_flash_ctrl.v]
// flash sequencer: erase, program, crc, security, boot select, serial programming link
`timescale 1ns/10ps
`include "fpbs_defs.vh"
module fpbs_flash_ctrl #(
  parameter SECTORS = 8,
  parameter [31:0] OP_CYCLES = `FPBS_OP_TIME_US * `FPBS_CLK_MHZ
) (
  input wire mclk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rom_call,
  input wire [15:0] rom_call_addr,
  input wire [7:0] rom_fn,
  input wire [15:0] rom_arg_addr,
  input wire [7:0] rom_arg_data,
  input wire code_rd_stb,
  input wire [15:0] code_rd_addr,
  output reg [7:0] code_rd_data,
  output reg code_rd_ack,
  output reg code_rd_refused,
  input wire loader_force,
  output reg [15:0] start_addr,
  output reg start_valid,
  output reg [7:0] user_power_up_config_byte,
  output reg op_busy,
  input wire icp_en,
  input wire icp_clk,
  input wire icp_data_i,
  output reg icp_data_o,
  output reg icp_data_oe
);
  localparam [15:0] MEM_BYTES = (SECTORS > 8) ? 16'h4000 : 16'h2000;
  localparam IW = (SECTORS > 8) ? 14 : 13;
  localparam [3:0] SECT_MASK = (SECTORS > 8) ? 4'hF : 4'h7;
  // default vector points at the shipped loader in the top 512 bytes
  localparam [7:0] VEC_DEF = (SECTORS > 8) ? `FPBS_VEC_LARGE : `FPBS_VEC_SMALL; // see R11 R17
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WALK = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  // non-volatile state: no reset, power-up image is the factory state
  reg [7:0] mem [0:(1 << IW) - 1];
  reg [7:0] secb [0:15];
  reg [7:0] boot_stat_q;
  reg [7:0] boot_vec_q;
  reg [7:0] cfg_flash_q;
  reg [7:0] pbuf [0:63];
  integer k;
  integer j;
  initial begin
    for (k = 0; k < (1 << IW); k = k + 1) mem[k] = `FPBS_ERASED;
    for (k = 0; k < 16; k = k + 1) secb[k] = 8'h00;
    boot_stat_q = 8'h01;
    boot_vec_q = VEC_DEF;
    cfg_flash_q = 8'h00;
  end

  function [3:0] sect_of;
    input [15:0] a;
    begin
      sect_of = a[13:10] & SECT_MASK; // see R06
    end
  endfunction

  function secured;
    input [15:0] a;
    begin
      secured = secb[sect_of(a)][0]; // see R16
    end
  endfunction

  reg [2:0] st_q;
  reg [3:0] op_q;
  reg [15:0] walk_q;
  reg [15:0] left_q;
  reg [31:0] tmr_q;
  reg [7:0] opdata_q;
  reg refused_q;
  reg crc_done_q;
  reg [31:0] crc_q;
  reg [7:0] data_q;
  reg [7:0] addrl_q;
  reg [7:0] addrh_q;
  reg [63:0] pmask_q;
  reg booted_q;
  reg icp_clk_q;
  reg [5:0] icp_cnt_q;
  reg [31:0] icp_sh_q;
  reg icp_fire_q;
  reg [31:0] icp_word_q;
  reg [7:0] icp_out_q;
  reg [3:0] icp_ocnt_q;

  wire [7:0] walk_byte = mem[walk_q[IW-1:0]];
  wire [31:0] crc_nx;
  fpbs_crc32_step u_crc (
    .crc_in(crc_q),
    .data_in(walk_byte),
    .crc_out(crc_nx)
  );

  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
  wire wb_go = wb_wr & (wb_adr_i == `FPBS_OFF_CTRL) & (wb_dat_i[3:0] != `FPBS_CMD_NONE);
  wire rom_go = rom_call & (rom_call_addr == `FPBS_ROM_ENTRY); // see R13
  wire icp_rise = icp_clk & ~icp_clk_q;
  wire [31:0] icp_frame = {icp_sh_q[30:0], icp_data_i};

  // one request per cycle: serial link first, then rom service, then registers
  reg req_v;
  reg [3:0] req_cmd;
  reg [15:0] req_addr;
  reg [7:0] req_data;
  always @* begin
    req_v = 1'b0;
    req_cmd = `FPBS_CMD_NONE;
    req_addr = 16'h0000;
    req_data = 8'h00;
    if (icp_fire_q) begin
      req_v = 1'b1;
      req_cmd = icp_word_q[27:24]; // see R18
      req_addr = icp_word_q[23:8];
      req_data = icp_word_q[7:0];
    end else if (rom_go) begin
      req_v = 1'b1;
      req_cmd = rom_fn[3:0]; // see R13
      req_addr = rom_arg_addr;
      req_data = rom_arg_data;
    end else if (wb_go) begin
      req_v = 1'b1;
      req_cmd = wb_dat_i[3:0]; // see R14
      req_addr = {addrh_q, addrl_q};
      req_data = data_q;
    end
  end

  // walk range of each timed command
  reg [15:0] req_base;
  reg [15:0] req_len;
  reg req_timed;
  always @* begin
    req_base = req_addr;
    req_len = 16'h0001;
    req_timed = 1'b1;
    case (req_cmd)
      `FPBS_CMD_PAGE_ERASE, `FPBS_CMD_PROGRAM: begin
        req_base = {req_addr[15:6], 6'h00}; // see R01 R04
        req_len = `FPBS_PAGE_BYTES;
      end
      `FPBS_CMD_SECT_ERASE, `FPBS_CMD_CRC_SECT: begin
        req_base = {req_addr[15:10], 10'h000}; // see R01 R08
        req_len = `FPBS_SECTOR_BYTES;
      end
      `FPBS_CMD_CHIP_ERASE, `FPBS_CMD_CRC_ALL: begin
        req_base = 16'h0000; // see R03 R08
        req_len = MEM_BYTES;
      end
      `FPBS_CMD_BYTE_ERASE, `FPBS_CMD_WR_SEC, `FPBS_CMD_WR_BSTAT,
      `FPBS_CMD_WR_BVEC, `FPBS_CMD_WR_CFG: begin
        req_len = 16'h0001; // see R02
      end
      default: begin
        req_timed = 1'b0;
      end
    endcase
  end

  wire is_erase = (op_q == `FPBS_CMD_BYTE_ERASE) | (op_q == `FPBS_CMD_PAGE_ERASE) |
                  (op_q == `FPBS_CMD_SECT_ERASE) | (op_q == `FPBS_CMD_CHIP_ERASE);
  wire is_crc = (op_q == `FPBS_CMD_CRC_SECT) | (op_q == `FPBS_CMD_CRC_ALL);
  wire walking = (st_q == ST_WALK);

  // non-volatile writes; programming can only clear bits
  always @(posedge mclk) begin
    if (walking) begin
      if (is_erase) begin
        mem[walk_q[IW-1:0]] <= `FPBS_ERASED; // see R22 R02
      end else if (op_q == `FPBS_CMD_PROGRAM && pmask_q[walk_q[5:0]]) begin
        mem[walk_q[IW-1:0]] <= walk_byte & pbuf[walk_q[5:0]]; // see R04
      end
      if (op_q == `FPBS_CMD_CHIP_ERASE) begin
        for (j = 0; j < 16; j = j + 1) secb[j] <= 8'h00;
      end
      case (op_q)
        `FPBS_CMD_WR_SEC: secb[sect_of(walk_q)] <= opdata_q; // see R16
        `FPBS_CMD_WR_BSTAT: boot_stat_q <= opdata_q;
        `FPBS_CMD_WR_BVEC: boot_vec_q <= opdata_q;
        `FPBS_CMD_WR_CFG: cfg_flash_q <= opdata_q;
        default: ;
      endcase
    end
    if (!rst && req_v && st_q == ST_IDLE && req_cmd == `FPBS_CMD_LOAD) begin
      pbuf[req_addr[5:0]] <= req_data; // see R04
    end
  end

  // sequencer and register side
  always @(posedge mclk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      op_q <= `FPBS_CMD_NONE;
      walk_q <= 16'h0000;
      left_q <= 16'h0000;
      tmr_q <= 32'h00000000;
      opdata_q <= 8'h00;
      op_busy <= 1'b0;
      refused_q <= 1'b0;
      crc_done_q <= 1'b0;
      crc_q <= `FPBS_CRC_INIT;
      data_q <= 8'h00;
      addrl_q <= 8'h00;
      addrh_q <= 8'h00;
      pmask_q <= 64'h0000000000000000;
    end else begin
      if (tmr_q != 32'h00000000) begin
        tmr_q <= tmr_q - 32'h00000001;
      end
      case (st_q)
        ST_IDLE: begin
          if (req_v && req_timed) begin
            st_q <= ST_WALK;
            op_q <= req_cmd;
            walk_q <= req_base;
            left_q <= req_len;
            opdata_q <= req_data;
            tmr_q <= OP_CYCLES - 32'h00000001; // see R05
            op_busy <= 1'b1; // see R21
            if (req_cmd == `FPBS_CMD_CRC_SECT || req_cmd == `FPBS_CMD_CRC_ALL) begin
              crc_q <= `FPBS_CRC_INIT;
              crc_done_q <= 1'b0;
            end
          end
        end
        ST_WALK: begin
          walk_q <= walk_q + 16'h0001;
          left_q <= left_q - 16'h0001;
          if (is_crc) begin
            crc_q <= crc_nx; // see R08
          end
          if (left_q == 16'h0001) begin
            if (is_crc) begin
              st_q <= ST_IDLE;
              op_busy <= 1'b0;
              crc_done_q <= 1'b1;
            end else begin
              st_q <= ST_WAIT;
            end
            if (op_q == `FPBS_CMD_PROGRAM) begin
              pmask_q <= 64'h0000000000000000;
            end
          end
        end
        ST_WAIT: begin
          // the operation ends at the fixed program/erase time or after the walk, whichever is later
          if (tmr_q == 32'h00000000) begin
            st_q <= ST_IDLE; // see R05
            op_busy <= 1'b0;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          op_busy <= 1'b0;
        end
      endcase
      if (req_v && st_q == ST_IDLE && req_cmd == `FPBS_CMD_LOAD) begin
        pmask_q[req_addr[5:0]] <= 1'b1;
      end
      if (req_v && st_q == ST_IDLE && req_cmd == `FPBS_CMD_READ) begin
        data_q <= secured(req_addr) ? 8'h00 : mem[req_addr[IW-1:0]]; // see R02
      end else if (wb_wr && wb_adr_i == `FPBS_OFF_DATA) begin
        data_q <= wb_dat_i[7:0];
      end
      if (wb_wr && wb_adr_i == `FPBS_OFF_ADDRL) begin
        addrl_q <= wb_dat_i[7:0];
      end
      if (wb_wr && wb_adr_i == `FPBS_OFF_ADDRH) begin
        addrh_q <= wb_dat_i[7:0];
      end
      // a new refusal wins over a software clear in the same cycle
      if (req_v && (st_q != ST_IDLE ||
          (req_cmd == `FPBS_CMD_READ && secured(req_addr)))) begin
        refused_q <= 1'b1; // see R21 R07
      end else if (wb_wr && wb_adr_i == `FPBS_OFF_CTRL && wb_dat_i[`FPBS_CTRL_CLR_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // wishbone read data and single-cycle acknowledge
  reg [31:0] rd_mux;
  always @* begin
    case (wb_adr_i)
      `FPBS_OFF_CTRL: rd_mux = {25'h0000000, crc_done_q, refused_q, op_busy, op_q};
      `FPBS_OFF_DATA: rd_mux = {24'h000000, data_q};
      `FPBS_OFF_ADDRL: rd_mux = {24'h000000, addrl_q};
      `FPBS_OFF_ADDRH: rd_mux = {24'h000000, addrh_q};
      `FPBS_OFF_CRC: rd_mux = crc_q;
      `FPBS_OFF_BOOT: rd_mux = {16'h0000, boot_stat_q, boot_vec_q};
      `FPBS_OFF_CFG: rd_mux = {16'h0000, cfg_flash_q, user_power_up_config_byte};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= (wb_hit && !wb_we_i) ? rd_mux : 32'h00000000;
    end
  end

  // code-space reads from the core
  always @(posedge mclk) begin
    if (rst) begin
      code_rd_ack <= 1'b0;
      code_rd_refused <= 1'b0;
      code_rd_data <= 8'h00;
    end else begin
      code_rd_ack <= code_rd_stb;
      code_rd_refused <= code_rd_stb & secured(code_rd_addr); // see R07
      code_rd_data <= (code_rd_stb && !secured(code_rd_addr)) ?
                      mem[code_rd_addr[IW-1:0]] : 8'h00; // see R07
    end
  end

  // start address and configuration are caught once, just after reset release
  always @(posedge mclk) begin
    if (rst) begin
      booted_q <= 1'b0;
      start_valid <= 1'b0;
      start_addr <= 16'h0000;
      user_power_up_config_byte <= 8'h00;
    end else if (!booted_q) begin
      booted_q <= 1'b1;
      start_valid <= 1'b1;
      user_power_up_config_byte <= cfg_flash_q; // see R15
      if (boot_stat_q != 8'h00 || loader_force) begin
        start_addr <= {boot_vec_q, `FPBS_BOOT_LOW}; // see R10 R12
      end else begin
        start_addr <= 16'h0000; // see R09
      end
    end
  end

  // serial programming link: frames of command, address, data, msb first
  always @(posedge mclk) begin
    if (rst) begin
      icp_clk_q <= 1'b0;
      icp_cnt_q <= 6'h00;
      icp_sh_q <= 32'h00000000;
      icp_fire_q <= 1'b0;
      icp_word_q <= 32'h00000000;
      icp_out_q <= 8'h00;
      icp_ocnt_q <= 4'h0;
      icp_data_o <= 1'b0;
      icp_data_oe <= 1'b0;
    end else begin
      icp_clk_q <= icp_clk;
      icp_fire_q <= 1'b0;
      if (!icp_en) begin
        icp_cnt_q <= 6'h00;
        icp_ocnt_q <= 4'h0;
        icp_data_oe <= 1'b0;
      end else if (icp_rise) begin
        if (icp_ocnt_q != 4'h0) begin
          icp_data_oe <= 1'b1; // see R18
          icp_data_o <= icp_out_q[7];
          icp_out_q <= {icp_out_q[6:0], 1'b0};
          icp_ocnt_q <= icp_ocnt_q - 4'h1;
        end else begin
          icp_data_oe <= 1'b0;
          icp_sh_q <= icp_frame;
          if (icp_cnt_q == `FPBS_ICP_FRAME_BITS - 6'd1) begin
            icp_cnt_q <= 6'h00;
            icp_word_q <= icp_frame;
            // the programmer reads regardless of sector security
            if (icp_frame[27:24] == `FPBS_CMD_READ) begin
              icp_out_q <= mem[icp_frame[IW+7:8]];
              icp_ocnt_q <= `FPBS_ICP_OUT_BITS;
            end else begin
              icp_fire_q <= 1'b1; // see R18
            end
          end else begin
            icp_cnt_q <= icp_cnt_q + 6'd1;
          end
        end
      end
    end
  end
endmodule

// [testbench/fpbs_flash_ctrl_assertions.sv]
// port checker for the flash sequencer
`timescale 1ns/10ps
module fpbs_flash_ctrl_chk #(
  parameter [31:0] OP_CYCLES = 100
) (
  input wire mclk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire code_rd_stb,
  input wire [7:0] code_rd_data,
  input wire code_rd_ack,
  input wire code_rd_refused,
  input wire [15:0] start_addr,
  input wire start_valid,
  input wire op_busy,
  input wire icp_en,
  input wire icp_data_oe
);
  // a whole-array erase, walk plus program/erase wait, is the longest busy span
  localparam int LIM = 8194;
  int busy_n;
  always @(posedge mclk) begin
    if (rst || !op_busy) busy_n <= 0;
    else busy_n <= busy_n + 1;
  end
  a_ack_next: assert property (@(posedge mclk) disable iff (rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (@(posedge mclk) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  a_rd_answer: assert property (@(posedge mclk) disable iff (rst)
    code_rd_stb |=> code_rd_ack) else $error("code read answer");
  a_refused_zero: assert property (@(posedge mclk) disable iff (rst)
    code_rd_refused |-> code_rd_data == 8'h00) else $error("refused read leaks data");
  a_busy_bounded: assert property (@(posedge mclk) disable iff (rst)
    busy_n <= LIM + OP_CYCLES) else $error("busy too long");
  a_start_after_rst: assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |=> start_valid) else $error("start not valid");
  a_start_low_zero: assert property (@(posedge mclk) disable iff (rst)
    start_valid |-> start_addr[7:0] == 8'h00) else $error("start low byte");
  a_icp_release: assert property (@(posedge mclk) disable iff (rst)
    !icp_en |=> !icp_data_oe) else $error("link driven while off");
endmodule
bind fpbs_flash_ctrl fpbs_flash_ctrl_chk #(.OP_CYCLES(OP_CYCLES)) chk_u (
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .code_rd_stb(code_rd_stb), .code_rd_data(code_rd_data),
  .code_rd_ack(code_rd_ack), .code_rd_refused(code_rd_refused), .start_addr(start_addr),
  .start_valid(start_valid), .op_busy(op_busy), .icp_en(icp_en), .icp_data_oe(icp_data_oe));

// [testbench/fpbs_icp_prog.sv]
// serial programmer model for the two-wire link
`timescale 1ns/10ps
module fpbs_icp_prog (
  input wire mclk,
  input wire icp_data_o,
  input wire icp_data_oe,
  output logic icp_en,
  output logic icp_clk,
  output logic icp_data_i
);
  initial begin
    icp_en = 1'b0;
    icp_clk = 1'b0;
    icp_data_i = 1'b1;
  end
  // msb first, clock stands low between frames
  // n_rd extra clocks shift a read answer back, sampled while it stands
  task automatic send(input logic [31:0] frame, input int n_rd, output logic [7:0] rd,
                      output logic oe_all);
    rd = 8'h00;
    oe_all = 1'b1;
    @(posedge mclk);
    icp_en <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(posedge mclk);
      icp_data_i <= frame[i];
      repeat (3) @(posedge mclk);
      icp_clk <= 1'b1;
      repeat (3) @(posedge mclk);
      icp_clk <= 1'b0;
    end
    for (int i = 0; i < n_rd; i++) begin
      repeat (4) @(posedge mclk);
      icp_clk <= 1'b1;
      repeat (3) @(posedge mclk);
      rd = {rd[6:0], icp_data_o};
      oe_all = oe_all & icp_data_oe;
      icp_clk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    // no pull on the line: show a changed value once released
    icp_data_i <= ~frame[0];
    icp_en <= 1'b0;
  endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the flash sequencer
`timescale 1ns/10ps
`include "fpbs_defs.vh"
module tb;
  logic mclk, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rcall = 1'b0, rd_stb = 1'b0;
  logic lf = 1'b0;
  logic [7:0] adr = 8'h00, rfn = 8'h00, rdat = 8'h00;
  logic [15:0] raddr = 16'h0000, rd_addr = 16'h0000, rca = 16'hFF03;
  logic [7:0] irb;
  logic ioe_all;
  wire [7:0] cfg;
  wire ido, ioe;
  logic [31:0] dat = 32'h0, rdv;
  wire [31:0] dat_o;
  wire [15:0] st_addr;
  wire [7:0] rd_data;
  wire ack, rd_ack, rd_ref, st_v, busy, ien, iclk, idat;
  int n_fail = 0;
  int n_compared = 0;
  fpbs_flash_ctrl #(.SECTORS(8), .OP_CYCLES(32'd100)) dut_u (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rom_call(rcall),
    .rom_call_addr(rca), .rom_fn(rfn), .rom_arg_addr(raddr), .rom_arg_data(rdat),
    .code_rd_stb(rd_stb), .code_rd_addr(rd_addr), .code_rd_data(rd_data),
    .code_rd_ack(rd_ack), .code_rd_refused(rd_ref), .loader_force(lf),
    .start_addr(st_addr), .start_valid(st_v), .user_power_up_config_byte(cfg),
    .op_busy(busy), .icp_en(ien), .icp_clk(iclk), .icp_data_i(idat), .icp_data_o(ido),
    .icp_data_oe(ioe));
  fpbs_icp_prog prog_u (.mclk(mclk), .icp_data_o(ido), .icp_data_oe(ioe), .icp_en(ien),
    .icp_clk(iclk), .icp_data_i(idat));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // reflected crc over ff bytes, init all ones, no final xor
  function automatic logic [31:0] crc_ff(input int n);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ 32'h000000FF;
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    return c;
  endfunction
  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // no cycle count assumed: only the watchdog ends a lost answer
    do @(posedge mclk); while (ack !== 1'b1);
    rdv = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
    wb(1'b1, `FPBS_OFF_ADDRL, {24'h0, a[7:0]});
    wb(1'b1, `FPBS_OFF_ADDRH, {24'h0, a[15:8]});
    wb(1'b1, `FPBS_OFF_DATA, {24'h0, d});
    wb(1'b1, `FPBS_OFF_CTRL, {28'h0, c});
  endtask
  task automatic idle();
    repeat (3) @(posedge mclk);
    while (busy !== 1'b0) @(posedge mclk);
  endtask
  task automatic crd(input logic [15:0] a, input logic rf, input logic [7:0] d);
    @(posedge mclk);
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(posedge mclk);
    check({rd_ref, rd_ack, rd_data}, {rf, 1'b1, d});
  endtask
  task automatic t_regs();
    wb(1'b1, `FPBS_OFF_ADDRL, 32'h0000005A);
    wb(1'b0, `FPBS_OFF_ADDRL, 32'h0);
    check(rdv, 32'h0000005A);
    wb(1'b0, 8'h40, 32'h0);
    check(rdv, 32'h0);
  endtask
  task automatic t_prog();
    cmd(`FPBS_CMD_LOAD, 16'h0085, 8'h3C);
    cmd(`FPBS_CMD_LOAD, 16'h0086, 8'hC3);
    cmd(`FPBS_CMD_PROGRAM, 16'h0080, 8'h00);
    idle();
    crd(16'h0085, 1'b0, 8'h3C);
    crd(16'h0086, 1'b0, 8'hC3);
    crd(16'h0087, 1'b0, 8'hFF);
    cmd(`FPBS_CMD_BYTE_ERASE, 16'h0085, 8'h00);
    idle();
    crd(16'h0085, 1'b0, 8'hFF);
    crd(16'h0086, 1'b0, 8'hC3);
    cmd(`FPBS_CMD_PAGE_ERASE, 16'h0080, 8'h00);
    idle();
    crd(16'h0086, 1'b0, 8'hFF);
  endtask
  task automatic t_busy();
    // a request during an erase must be dropped and flagged
    cmd(`FPBS_CMD_SECT_ERASE, 16'h0400, 8'h00);
    wb(1'b1, `FPBS_OFF_CTRL, {28'h0, `FPBS_CMD_LOAD});
    wb(1'b0, `FPBS_OFF_CTRL, 32'h0);
    check(rdv[5:4], 2'b11);
    idle();
    wb(1'b1, `FPBS_OFF_CTRL, 32'h00000080);
    wb(1'b0, `FPBS_OFF_CTRL, 32'h0);
    check(rdv[5:4], 2'b00);
  endtask
  task automatic t_secure();
    cmd(`FPBS_CMD_LOAD, 16'h0010, 8'hA5);
    cmd(`FPBS_CMD_PROGRAM, 16'h0000, 8'h00);
    idle();
    cmd(`FPBS_CMD_WR_SEC, 16'h0400, 8'h01);
    idle();
    crd(16'h0410, 1'b1, 8'h00);
    crd(16'h0010, 1'b0, 8'hA5);
    cmd(`FPBS_CMD_READ, 16'h0010, 8'h00);
    wb(1'b0, `FPBS_OFF_DATA, 32'h0);
    check(rdv, 32'h000000A5);
    cmd(`FPBS_CMD_CHIP_ERASE, 16'h0000, 8'h00);
    idle();
    crd(16'h0410, 1'b0, 8'hFF);
    crd(16'h0010, 1'b0, 8'hFF);
  endtask
  task automatic t_crc();
    cmd(`FPBS_CMD_CRC_SECT, 16'h0000, 8'h00);
    idle();
    wb(1'b0, `FPBS_OFF_CRC, 32'h0);
    check(rdv, crc_ff(1024));
    cmd(`FPBS_CMD_CRC_ALL, 16'h0000, 8'h00);
    idle();
    wb(1'b0, `FPBS_OFF_CRC, 32'h0);
    check(rdv, crc_ff(8192));
  endtask
  task automatic t_icp();
    cmd(`FPBS_CMD_LOAD, 16'h0020, 8'h5A);
    cmd(`FPBS_CMD_PROGRAM, 16'h0000, 8'h00);
    idle();
    crd(16'h0020, 1'b0, 8'h5A);
    prog_u.send({4'h0, `FPBS_CMD_READ, 16'h0020, 8'h00}, 8, irb, ioe_all);
    check({ioe_all, irb}, {1'b1, 8'h5A});
    prog_u.send({4'h0, `FPBS_CMD_BYTE_ERASE, 16'h0020, 8'h00}, 0, irb, ioe_all);
    idle();
    crd(16'h0020, 1'b0, 8'hFF);
  endtask
  task automatic rom(input logic [15:0] ca, input logic [3:0] fn);
    @(posedge mclk);
    rcall <= 1'b1;
    rca <= ca;
    rfn <= {4'h0, fn};
    @(posedge mclk);
    rcall <= 1'b0;
  endtask
  task automatic t_boot();
    check({st_v, st_addr}, {1'b1, 16'h1F00});
    rom(16'hFF00, `FPBS_CMD_WR_BSTAT);
    @(posedge mclk);
    check(busy, 1'b0);
    rom(16'hFF03, `FPBS_CMD_WR_BSTAT);
    idle();
    cmd(`FPBS_CMD_WR_CFG, 16'h0000, 8'hA7);
    idle();
    wb(1'b0, `FPBS_OFF_CFG, 32'h0);
    check(rdv, 32'h0000A700);
    do_reset();
    check({st_v, st_addr, cfg}, {1'b1, 16'h0000, 8'hA7});
    lf <= 1'b1;
    do_reset();
    check({st_v, st_addr}, {1'b1, 16'h1F00});
  endtask
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // all scenarios take about 20000 cycles
  initial begin
    #500000;
    n_fail++;
    end_of_test();
  end
  initial begin
    do_reset();
    t_regs();
    t_prog();
    t_busy();
    t_secure();
    t_crc();
    t_icp();
    t_boot();
    end_of_test();
  end
endmodule
